// >>> design/alternate_function_pin_mux.sv
// Alternate function pin multiplexer with remap register
`timescale 1ns/10ps
`include "pin_mux_defines.svh"

module alternate_function_pin_mux
    import pin_mux_pkg::*;
#(
    parameter int PINS  = `PIN_COUNT,
    parameter int SLOTS = `SLOT_COUNT
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // Remap register access
    input  wire logic                    remap_write_en,
    input  wire logic [`REMAP_WIDTH-1:0] remap_wdata,
    output logic      [`REMAP_WIDTH-1:0] function_remap_select_reg,
    // General-purpose port state
    input  wire logic [31:0]             gpio_out_a,
    input  wire logic [31:0]             gpio_oe_a,
    input  wire logic [31:0]             gpio_out_b,
    input  wire logic [31:0]             gpio_oe_b,
    // Pads
    input  wire logic [31:0]             pad_in_a,
    input  wire logic [31:0]             pad_in_b,
    output logic      [31:0]             pad_out_a_reg,
    output logic      [31:0]             pad_oe_a_reg,
    output logic      [31:0]             pad_pull_en_a_reg,
    output logic      [31:0]             pad_claimed_a_reg,
    output logic      [31:0]             pad_out_b_reg,
    output logic      [31:0]             pad_oe_b_reg,
    output logic      [31:0]             pad_pull_en_b_reg,
    output logic      [31:0]             pad_claimed_b_reg,
    // Serial peripheral
    input  spi_mode_s                    spi_mode,
    input  wire logic                    spi_clk_out,
    input  wire logic                    spi_select_out_n,
    input  wire logic                    spi_mosi_out,
    input  wire logic                    spi_miso_out,
    output logic                         serial_periph_clock_in_reg,
    output logic                         serial_periph_select_in_n_reg,
    output logic                         spi_mosi_in_reg,
    output logic                         spi_miso_in_reg,
    // Uarts
    input  wire logic [2:0]              uart_enable,
    input  wire logic [2:0]              uart_transmit_line,
    output logic      [1:0]              uart_receive_line_reg,
    // Timers 0..2 and pwm channel eleven
    input  timer_ctl_s                   timer_ctl [3],
    output logic      [2:0]              timer_capture_in_reg,
    input  wire logic                    pwm_eleven_enable,
    input  wire logic                    pwm_output_eleven,
    // Reset input function
    input  wire logic                    reset_pin_enable,
    output logic                         reset_pin_in_n_reg,
    // Analog and USB
    input  wire logic [31:0]             analog_input_channel_a,
    input  wire logic [31:0]             analog_input_channel_b,
    input  wire logic                    usb_enable,
    output logic                         usb_pad_route_reg,
    output logic      [1:0]              usb_pad_oe_reg,
    output logic      [1:0]              usb_pad_pull_en_reg
);

    if (PINS != `PIN_COUNT || SLOTS < `SLOT_COUNT) begin : g_check
        $error("pin map needs 64 pins and at least 4 priority slots");
    end

    fn_drive_s          slots [PINS][SLOTS];
    logic [PINS-1:0]    pad_in;
    logic [PINS-1:0]    pad_out;
    logic [PINS-1:0]    pad_oe;
    logic [PINS-1:0]    pad_pull;
    logic [PINS-1:0]    pad_claimed;
    logic               spi_remap;
    logic               uart1_remap;
    logic               uart0_remap;
    logic [2:0]         tmr_remap;
    logic               spi_full_master;
    logic               spi_full_slave;
    logic               spi_slave;
    logic [PINS-1:0]    analog_all;

    function automatic fn_drive_s drive(input logic claim, input logic out,
                                        input logic oe, input logic pull_ok);
        drive = {claim, out, oe, pull_ok};
    endfunction

    function automatic int unsigned pick(input logic sel, input int unsigned def_pin,
                                         input int unsigned alt_pin);
        pick = sel ? alt_pin : def_pin;
    endfunction

    assign pad_in = {pad_in_b, pad_in_a};
    assign analog_all = {analog_input_channel_b, analog_input_channel_a};

    // Remap register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            function_remap_select_reg <= `REMAP_RESET;
        end else if (remap_write_en) begin
            function_remap_select_reg <= remap_wdata & `REMAP_RW_MASK;
        end
    end

    assign spi_remap   = function_remap_select_reg[`REMAP_SPI_BIT];
    assign uart1_remap = function_remap_select_reg[`REMAP_UART1_BIT];
    assign uart0_remap = function_remap_select_reg[`REMAP_UART0_BIT];
    assign tmr_remap   = {function_remap_select_reg[`REMAP_TMR2_BIT],
                          function_remap_select_reg[`REMAP_TMR1_BIT],
                          function_remap_select_reg[`REMAP_FIRST_TIMER_ALT_PIN_BIT]};

    assign spi_full_master = spi_mode.enable && spi_mode.master && !spi_mode.half_duplex;
    assign spi_full_slave  = spi_mode.enable && !spi_mode.master && !spi_mode.half_duplex;
    assign spi_slave       = spi_mode.enable && !spi_mode.master;

    // Build each pin's function requests; unclaimed valid pins stay general-purpose
    always_comb begin
        int unsigned p;
        p = 0;
        for (int i = 0; i < PINS; i++) begin
            for (int s = 0; s < SLOTS; s++) begin
                slots[i][s] = '0;
            end
        end
        if (spi_mode.enable) begin
            p = pick(spi_remap, `SPI_SCK_DEF, `SPI_SCK_ALT);
            slots[p][`SLOT_TOP] = drive(1'b1, spi_clk_out, spi_mode.master,
                !spi_mode.master);
            p = pick(spi_remap, `SPI_CS_DEF, `SPI_CS_ALT);
            // Master may hand the select to any general pin instead
            slots[p][`SLOT_TOP] = drive(!spi_mode.master || spi_mode.cs_out_en,
                spi_select_out_n, spi_mode.master, 1'b1);
            p = pick(spi_remap, `SPI_MOSI_DEF, `SPI_MOSI_ALT);
            slots[p][`SLOT_TOP] = drive(!spi_mode.half_duplex, spi_mosi_out,
                spi_full_master, !spi_full_master);
            p = pick(spi_remap, `SPI_MISO_DEF, `SPI_MISO_ALT);
            if (spi_slave) begin
                // Drive only while the select pin is low
                slots[p][`SLOT_TOP] = drive(1'b1, spi_miso_out,
                    !serial_periph_select_in_n_reg, 1'b1);
            end else if (spi_mode.half_duplex) begin
                // Direction is left to the port's own direction bit
                slots[p][`SLOT_TOP] = drive(1'b1, spi_mosi_out,
                    pad_oe_dir(p), 1'b1);
            end else begin
                slots[p][`SLOT_TOP] = drive(1'b1, 1'b0, 1'b0, 1'b1);
            end
        end
        if (uart_enable[1]) begin
            slots[pick(uart1_remap, `UART1_RX_DEF, `UART1_RX_ALT)][`SLOT_UART] =
                drive(1'b1, 1'b0, 1'b0, 1'b1);
            slots[pick(uart1_remap, `UART1_TX_DEF, `UART1_TX_ALT)][`SLOT_UART] =
                drive(1'b1, uart_transmit_line[1], 1'b1, 1'b1);
        end
        if (uart_enable[0]) begin
            slots[pick(uart0_remap, `UART0_RX_DEF, `UART0_RX_ALT)][`SLOT_UART] =
                drive(1'b1, 1'b0, 1'b0, 1'b1);
            slots[pick(uart0_remap, `UART0_TX_DEF, `UART0_TX_ALT)][`SLOT_UART] =
                drive(1'b1, uart_transmit_line[0], 1'b1, 1'b1);
        end
        for (int t = 0; t < 3; t++) begin
            if (timer_ctl[t].enable) begin
                p = tmr_pin(t, tmr_remap[t]);
                slots[p][(p == `RESET_PIN) ? 1 : `SLOT_TIMER] =
                    drive(1'b1, timer_ctl[t].pwm_out, timer_ctl[t].pwm_mode, 1'b1);
            end
        end
        // Shared pin: reset input, timer0 alternate, uart2 transmit, pwm eleven
        slots[`RESET_PIN][`SLOT_TOP] = drive(reset_pin_enable, 1'b0, 1'b0, 1'b1);
        slots[`UART2_TX_PIN][2] = drive(uart_enable[2], uart_transmit_line[2],
            1'b1, 1'b1);
        slots[`PWM_OUTPUT_ELEVEN_PIN][`SLOT_LOW] = drive(pwm_eleven_enable, pwm_output_eleven,
            1'b1, 1'b1);
        // Analog channels win over digital functions and float
        for (int i = 0; i < PINS; i++) begin
            if (analog_all[i]) begin
                slots[i][`SLOT_TOP] = drive(1'b1, 1'b0, 1'b0, 1'b0);
            end
        end
    end

    function automatic logic pad_oe_dir(input int unsigned pin);
        pad_oe_dir = (pin < `PORT_B_BASE) ? gpio_oe_a[pin[4:0]] : gpio_oe_b[pin[4:0]];
    endfunction

    function automatic int unsigned tmr_pin(input int t, input logic sel);
        case (t)
            0:       tmr_pin = pick(sel, `FIRST_TIMER_ALT_PIN_DEF, `FIRST_TIMER_ALT_PIN_ALT);
            1:       tmr_pin = pick(sel, `TMR1_DEF, `TMR1_ALT);
            default: tmr_pin = pick(sel, `TMR2_DEF, `TMR2_ALT);
        endcase
    endfunction

    pad_select #(
        .PINS  (PINS),
        .SLOTS (SLOTS)
    ) u_pad_select (
        .clk             (clk),
        .reset_n         (reset_n),
        .slots           (slots),
        .gpio_out        ({gpio_out_b, gpio_out_a}),
        .gpio_oe         ({gpio_oe_b, gpio_oe_a}),
        .valid_mask      ({`PORT_B_VALID_MASK, `PORT_A_VALID_MASK}),
        .pad_out_reg     (pad_out),
        .pad_oe_reg      (pad_oe),
        .pad_pull_en_reg (pad_pull),
        .pad_claimed_reg (pad_claimed)
    );

    assign {pad_out_b_reg, pad_out_a_reg}         = pad_out;
    assign {pad_oe_b_reg, pad_oe_a_reg}           = pad_oe;
    assign {pad_pull_en_b_reg, pad_pull_en_a_reg} = pad_pull;
    assign {pad_claimed_b_reg, pad_claimed_a_reg} = pad_claimed;

    // Inputs sampled from whichever pin the remap selects
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_periph_clock_in_reg    <= 1'b0;
            serial_periph_select_in_n_reg <= 1'b1;
            spi_mosi_in_reg               <= 1'b0;
            spi_miso_in_reg               <= 1'b0;
        end else begin
            serial_periph_clock_in_reg    <= pad_in[pick(spi_remap, `SPI_SCK_DEF,
                `SPI_SCK_ALT)];
            serial_periph_select_in_n_reg <= spi_slave ? pad_in[pick(spi_remap,
                `SPI_CS_DEF, `SPI_CS_ALT)] : 1'b1;
            spi_mosi_in_reg               <= pad_in[pick(spi_remap, `SPI_MOSI_DEF,
                `SPI_MOSI_ALT)];
            spi_miso_in_reg               <= pad_in[pick(spi_remap, `SPI_MISO_DEF,
                `SPI_MISO_ALT)];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            uart_receive_line_reg <= 2'h3;
            reset_pin_in_n_reg    <= 1'b1;
        end else begin
            uart_receive_line_reg <= {pad_in[pick(uart1_remap, `UART1_RX_DEF,
                `UART1_RX_ALT)] | !uart_enable[1],
                pad_in[pick(uart0_remap, `UART0_RX_DEF,
                `UART0_RX_ALT)] | !uart_enable[0]};
            reset_pin_in_n_reg    <= pad_in[`RESET_PIN] | !reset_pin_enable;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_capture_in_reg <= 3'h0;
        end else begin
            for (int t = 0; t < 3; t++) begin
                timer_capture_in_reg[t] <= pad_in[tmr_pin(t, tmr_remap[t])];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            usb_pad_route_reg   <= 1'b0;
            usb_pad_oe_reg      <= 2'h0;
            usb_pad_pull_en_reg <= 2'h3;
        end else begin
            usb_pad_route_reg   <= usb_enable;
            usb_pad_oe_reg      <= 2'h0;
            usb_pad_pull_en_reg <= {2{!usb_enable}};
        end
    end

endmodule

// >>> design/pin_mux_defines.svh
// Pin indices, remap bit positions and reset values for the pin multiplexer
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH

// Flat pin numbering: port A bits 0..31, port B bits 32..63
`define PORT_B_BASE        32
`define PIN_COUNT          64
`define PORT_A_VALID_MASK  32'h0000FF30
`define PORT_B_VALID_MASK  32'h00C0FCD1

// Remap register layout
`define REMAP_WIDTH        16
`define REMAP_RESET        16'h0000
`define REMAP_RW_MASK      16'h0137
`define REMAP_SPI_BIT      8
`define REMAP_UART1_BIT    5
`define REMAP_UART0_BIT    4
`define REMAP_TMR2_BIT     2
`define REMAP_TMR1_BIT     1
`define REMAP_FIRST_TIMER_ALT_PIN_BIT     0

// Serial peripheral pins: clock, select, master-out, master-in
`define SPI_SCK_DEF        12
`define SPI_CS_DEF         13
`define SPI_MOSI_DEF       14
`define SPI_MISO_DEF       15
`define SPI_SCK_ALT        44
`define SPI_CS_ALT         45
`define SPI_MOSI_ALT       46
`define SPI_MISO_ALT       47

// Uart receive/transmit pins
`define UART1_RX_DEF       8
`define UART1_TX_DEF       9
`define UART1_RX_ALT       44
`define UART1_TX_ALT       45
`define UART0_RX_DEF       36
`define UART0_TX_DEF       39
`define UART0_RX_ALT       15
`define UART0_TX_ALT       14
`define UART2_TX_PIN       55

// Timer pins
`define TMR2_DEF           11
`define TMR2_ALT           43
`define TMR1_DEF           10
`define TMR1_ALT           42
`define FIRST_TIMER_ALT_PIN_DEF           9
`define FIRST_TIMER_ALT_PIN_ALT           55
`define PWM_OUTPUT_ELEVEN_PIN          55
`define RESET_PIN          55

// Priority slots, 0 is highest
`define SLOT_COUNT         4
`define SLOT_TOP           0
`define SLOT_UART          1
`define SLOT_TIMER         2
`define SLOT_LOW           3

`endif

// >>> design/pin_mux_pkg.sv
// Types shared by the pin multiplexer modules
package pin_mux_pkg;

    // What one alternate function asks of one pad
    typedef struct packed {
        logic claim;
        logic out;
        logic oe;
        logic pull_ok;
    } fn_drive_s;

    // Serial peripheral mode controls
    typedef struct packed {
        logic enable;
        logic master;
        logic half_duplex;
        logic cs_out_en;
    } spi_mode_s;

    // Timer controls: enable and pwm (1) or capture (0)
    typedef struct packed {
        logic enable;
        logic pwm_mode;
        logic pwm_out;
    } timer_ctl_s;

endpackage

// >>> design/pad_select.sv
// Per-pad priority select between general-purpose and alternate functions
`timescale 1ns/10ps
module pad_select
    import pin_mux_pkg::*;
#(
    parameter int PINS  = 64,
    parameter int SLOTS = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Requests
    input  fn_drive_s             slots [PINS][SLOTS],
    input  wire logic [PINS-1:0]  gpio_out,
    input  wire logic [PINS-1:0]  gpio_oe,
    input  wire logic [PINS-1:0]  valid_mask,
    // Pads
    output logic      [PINS-1:0]  pad_out_reg,
    output logic      [PINS-1:0]  pad_oe_reg,
    output logic      [PINS-1:0]  pad_pull_en_reg,
    output logic      [PINS-1:0]  pad_claimed_reg
);

    if (SLOTS < 1 || PINS < 1) begin : g_check
        $error("pad_select needs at least one pin and one slot");
    end

    logic [PINS-1:0] out_next;
    logic [PINS-1:0] oe_next;
    logic [PINS-1:0] pull_next;
    logic [PINS-1:0] claimed_next;

    always_comb begin
        for (int p = 0; p < PINS; p++) begin
            out_next[p]     = gpio_out[p];
            oe_next[p]      = gpio_oe[p];
            pull_next[p]    = 1'b1;
            claimed_next[p] = 1'b0;
            // Lowest slot number is applied last and so wins
            for (int s = SLOTS - 1; s >= 0; s--) begin
                if (slots[p][s].claim) begin
                    out_next[p]     = slots[p][s].out;
                    oe_next[p]      = slots[p][s].oe;
                    pull_next[p]    = slots[p][s].pull_ok;
                    claimed_next[p] = 1'b1;
                end
            end
            if (!valid_mask[p]) begin
                out_next[p]     = 1'b0;
                oe_next[p]      = 1'b0;
                pull_next[p]    = 1'b0;
                claimed_next[p] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pad_out_reg     <= '0;
            pad_oe_reg      <= '0;
            pad_pull_en_reg <= '0;
            pad_claimed_reg <= '0;
        end else begin
            pad_out_reg     <= out_next;
            pad_oe_reg      <= oe_next;
            pad_pull_en_reg <= pull_next;
            pad_claimed_reg <= claimed_next;
        end
    end

endmodule

// >>> verification/pin_mux_props.sv
// Concurrent checks on the pin multiplexer ports
`timescale 1ns/10ps
`include "pin_mux_defines.svh"
module pin_mux_props
    import pin_mux_pkg::*;
(
    // Clock, reset and remap
    input wire logic                    clk,
    input wire logic                    reset_n,
    input wire logic                    remap_write_en,
    input wire logic [`REMAP_WIDTH-1:0] remap_wdata,
    input wire logic [`REMAP_WIDTH-1:0] function_remap_select_reg,
    // Pads
    input wire logic [31:0]             pad_in_a,
    input wire logic [31:0]             pad_out_a_reg,
    input wire logic [31:0]             pad_oe_a_reg,
    input wire logic [31:0]             pad_pull_en_a_reg,
    input wire logic [31:0]             pad_claimed_a_reg,
    input wire logic [31:0]             pad_out_b_reg,
    input wire logic [31:0]             pad_oe_b_reg,
    input wire logic [31:0]             pad_claimed_b_reg,
    input wire logic [31:0]             analog_input_channel_a,
    input wire logic [31:0]             analog_input_channel_b,
    // Peripherals
    input spi_mode_s                    spi_mode,
    input wire logic                    spi_clk_out,
    input wire logic                    spi_miso_out,
    input wire logic                    serial_periph_select_in_n_reg,
    input wire logic [2:0]              uart_enable,
    input wire logic [2:0]              uart_transmit_line,
    input timer_ctl_s                   timer_ctl [3],
    input wire logic [2:0]              timer_capture_in_reg,
    input wire logic                    pwm_eleven_enable,
    input wire logic                    pwm_output_eleven,
    input wire logic                    reset_pin_enable,
    input wire logic                    usb_enable,
    input wire logic                    usb_pad_route_reg,
    input wire logic [1:0]              usb_pad_oe_reg,
    input wire logic [1:0]              usb_pad_pull_en_reg
);
    wire logic [15:0] remap = function_remap_select_reg;
    wire logic        spi_on = spi_mode.enable && !remap[8];
    wire logic        slave = spi_on && !spi_mode.master && !analog_input_channel_a[15];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    remap_write_a: assert property (remap_write_en |=>
        function_remap_select_reg == ($past(remap_wdata) & 16'h0137))
        else $error("bad remap value");
    spi_master_a: assert property (spi_on && spi_mode.master && !analog_input_channel_a[12] |=>
        pad_oe_a_reg[12] && pad_out_a_reg[12] == $past(spi_clk_out) && !pad_pull_en_a_reg[12])
        else $error("master clock undriven");
    slave_miso_a: assert property (slave && !serial_periph_select_in_n_reg |=>
        pad_oe_a_reg[15] && pad_out_a_reg[15] == $past(spi_miso_out))
        else $error("slave data-out undriven");
    slave_idle_a: assert property (slave && serial_periph_select_in_n_reg |=>
        !pad_oe_a_reg[15])
        else $error("idle slave data-out driven");
    half_free_a: assert property (spi_on && spi_mode.half_duplex && !analog_input_channel_a[14]
        && !(uart_enable[0] && remap[4]) |=> !pad_claimed_a_reg[14])
        else $error("half duplex pin claimed");
    uart1_tx_a: assert property (uart_enable[1] && !remap[5] && !analog_input_channel_a[9] |=>
        pad_oe_a_reg[9] && pad_out_a_reg[9] == $past(uart_transmit_line[1]))
        else $error("uart1 transmit lost");
    reset_pin_a: assert property (reset_pin_enable && !analog_input_channel_b[23] |=>
        pad_claimed_b_reg[23] && !pad_oe_b_reg[23])
        else $error("reset input lost");
    pwm_low_a: assert property (pwm_eleven_enable && !reset_pin_enable && !uart_enable[2]
        && !(timer_ctl[0].enable && remap[0]) && !analog_input_channel_b[23]
        |=> pad_oe_b_reg[23] && pad_out_b_reg[23] == $past(pwm_output_eleven))
        else $error("pwm eleven undriven");
    capture_in_a: assert property (timer_ctl[1].enable && !timer_ctl[1].pwm_mode && !remap[1]
        && !analog_input_channel_a[10]
        |=> !pad_oe_a_reg[10] && timer_capture_in_reg[1] == $past(pad_in_a[10]))
        else $error("capture pin driven");
    analog_float_a: assert property (analog_input_channel_a != 32'h0 |=>
        ((pad_oe_a_reg | pad_pull_en_a_reg) & $past(analog_input_channel_a)) == 32'h0)
        else $error("analog pin driven or pulled");
    usb_float_a: assert property (usb_enable |=>
        usb_pad_route_reg && usb_pad_oe_reg == 2'h0 && usb_pad_pull_en_reg == 2'h0)
        else $error("usb pads not floating");

    cover property (slave && !serial_periph_select_in_n_reg);
    cover property (pwm_eleven_enable && reset_pin_enable);
    cover property (remap_write_en && remap_wdata[8]);
endmodule

bind alternate_function_pin_mux pin_mux_props props (.*);

// >>> verification/pad_world.sv
// Pad levels seen by the device: own drive or the external device
`timescale 1ns/10ps
module pad_world (
    // Device drive
    input wire logic [31:0] pad_out_a_reg,
    input wire logic [31:0] pad_oe_a_reg,
    input wire logic [31:0] pad_out_b_reg,
    input wire logic [31:0] pad_oe_b_reg,
    // External levels
    input wire logic [31:0] ext_a,
    input wire logic [31:0] ext_b,
    // Resolved pads
    output logic     [31:0] pad_in_a,
    output logic     [31:0] pad_in_b
);
    assign pad_in_a = (pad_oe_a_reg & pad_out_a_reg) | (~pad_oe_a_reg & ext_a);
    assign pad_in_b = (pad_oe_b_reg & pad_out_b_reg) | (~pad_oe_b_reg & ext_b);
endmodule

// >>> verification/alternate_function_pin_mux_bench.sv
// Self-checking bench for the pin multiplexer
`timescale 1ns/10ps
`include "pin_mux_defines.svh"
module alternate_function_pin_mux_bench
    import pin_mux_pkg::*;
;
    typedef struct packed {
        logic [15:0] remap;
        logic [3:0]  spi;
        logic [2:0]  uart;
        logic [2:0]  tmr;
        logic [5:0]  pin;
        logic [2:0]  exp;
    } row_s;
    logic                    clk = 1'b0, reset_n = 1'b0, remap_write_en;
    logic [`REMAP_WIDTH-1:0] remap_wdata, function_remap_select_reg;
    logic [31:0]             gpio_out_a, gpio_oe_a, gpio_out_b, gpio_oe_b, pad_in_a, pad_in_b;
    logic [31:0]             pad_out_a_reg, pad_oe_a_reg, pad_pull_en_a_reg, pad_claimed_a_reg;
    logic [31:0]             pad_out_b_reg, pad_oe_b_reg, pad_pull_en_b_reg, pad_claimed_b_reg;
    logic [31:0]             analog_input_channel_a, analog_input_channel_b, ext_a, ext_b;
    spi_mode_s               spi_mode;
    logic                    spi_clk_out, spi_select_out_n, spi_mosi_out, spi_miso_out;
    logic                    serial_periph_clock_in_reg, serial_periph_select_in_n_reg;
    logic                    spi_mosi_in_reg, spi_miso_in_reg, usb_enable, usb_pad_route_reg;
    logic [2:0]              uart_enable, uart_transmit_line, timer_capture_in_reg;
    logic [1:0]              uart_receive_line_reg, usb_pad_oe_reg, usb_pad_pull_en_reg;
    timer_ctl_s              timer_ctl [3];
    logic                    pwm_eleven_enable, pwm_output_eleven;
    logic                    reset_pin_enable, reset_pin_in_n_reg;
    int                      fails = 0, n_tests = 0, cycles = 0;
    wire logic [63:0]        po = {pad_out_b_reg, pad_out_a_reg};
    wire logic [63:0]        poe = {pad_oe_b_reg, pad_oe_a_reg};
    wire logic [63:0]        pcl = {pad_claimed_b_reg, pad_claimed_a_reg};
    row_s rows [16] = '{
        '{16'h0000, 4'h0, 3'h0, 3'h0, 6'h0C, 3'h0},
        '{16'h0000, 4'hC, 3'h0, 3'h0, 6'h0C, 3'h7},
        '{16'h0000, 4'hC, 3'h0, 3'h0, 6'h2C, 3'h0},
        '{16'h0100, 4'hC, 3'h0, 3'h0, 6'h2C, 3'h7},
        '{16'h0100, 4'hC, 3'h0, 3'h0, 6'h0C, 3'h0},
        '{16'h0000, 4'hC, 3'h0, 3'h0, 6'h0E, 3'h7},
        '{16'h0000, 4'hE, 3'h0, 3'h0, 6'h0E, 3'h0},
        '{16'h0000, 4'hD, 3'h0, 3'h0, 6'h0D, 3'h7},
        '{16'h0000, 4'h0, 3'h2, 3'h0, 6'h09, 3'h7},
        '{16'h0020, 4'h0, 3'h2, 3'h0, 6'h2D, 3'h7},
        '{16'h0000, 4'h0, 3'h1, 3'h0, 6'h27, 3'h7},
        '{16'h0010, 4'h0, 3'h1, 3'h0, 6'h0E, 3'h7},
        '{16'h0000, 4'h0, 3'h0, 3'h4, 6'h0B, 3'h7},
        '{16'h0004, 4'h0, 3'h0, 3'h4, 6'h2B, 3'h7},
        '{16'h0002, 4'h0, 3'h0, 3'h2, 6'h2A, 3'h7},
        '{16'h0001, 4'h0, 3'h0, 3'h1, 6'h37, 3'h7}
    };

    alternate_function_pin_mux dut (.*);
    pad_world world (.*);

    always #50 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic idle_all();
        remap_write_en = 1'b1;
        remap_wdata = 16'h0000;
        {gpio_out_a, gpio_oe_a, gpio_out_b, gpio_oe_b} = 128'h0;
        {analog_input_channel_a, analog_input_channel_b} = 64'h0;
        {ext_a, ext_b} = {64{1'b1}};
        spi_mode = 4'h0;
        {spi_clk_out, spi_select_out_n, spi_mosi_out, spi_miso_out} = 4'hF;
        uart_enable = 3'h0;
        uart_transmit_line = 3'h7;
        foreach (timer_ctl[k]) timer_ctl[k] = '{1'b0, 1'b1, 1'b1};
        {pwm_eleven_enable, pwm_output_eleven, reset_pin_enable, usb_enable} = 4'h4;
    endtask

    task automatic report_and_stop();
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        idle_all();
        remap_write_en = 1'b0;
        {gpio_out_a, gpio_oe_a} = {64{1'b1}};
        step(4);
        chk({16'h0, function_remap_select_reg}, 32'h0);
        reset_n = 1'b1;
        step(2);
        chk(pad_claimed_a_reg | pad_claimed_b_reg, 32'h0);
        chk(pad_oe_a_reg, 32'h0000FF30);
        foreach (rows[i]) begin
            idle_all();
            remap_wdata = rows[i].remap;
            spi_mode = rows[i].spi;
            uart_enable = rows[i].uart;
            foreach (timer_ctl[k]) timer_ctl[k] = '{rows[i].tmr[k], 1'b1, 1'b1};
            step(2);
            chk({29'h0, pcl[rows[i].pin], poe[rows[i].pin], po[rows[i].pin]}, {29'h0, rows[i].exp});
        end
        remap_wdata = 16'hFFFF;
        step(1);
        chk({16'h0, function_remap_select_reg}, 32'h00000137);
        for (int k = 0; k < 4; k++) begin
            remap_wdata = 16'h0001;
            reset_pin_enable = (k == 0);
            timer_ctl[0] = '{k <= 1, 1'b1, k == 1};
            uart_enable = (k <= 2) ? 3'h4 : 3'h0;
            uart_transmit_line = (k == 2) ? 3'h7 : 3'h3;
            pwm_eleven_enable = 1'b1;
            pwm_output_eleven = (k == 3);
            step(2);
            chk({29'h0, pcl[55], poe[55], po[55]}, (k == 0) ? 32'h4 : 32'h7);
        end
        foreach (rows[m]) if (m < 2) begin
            idle_all();
            spi_mode = (m == 0) ? 4'h8 : 4'hA;
            step(2);
            chk({30'h0, poe[15], poe[12]}, 32'h0);
            ext_a[13] = 1'b0;
            step(2);
            chk({30'h0, poe[15], po[15]}, 32'h3);
        end
        idle_all();
        spi_mode = 4'hE;
        gpio_oe_a[15] = 1'b1;
        step(2);
        chk({30'h0, poe[15], pcl[14]}, 32'h2);
        idle_all();
        timer_ctl[1] = '{1'b1, 1'b0, 1'b0};
        spi_mode = 4'hC;
        analog_input_channel_a[12] = 1'b1;
        usb_enable = 1'b1;
        ext_a[12] = 1'b0;
        step(2);
        chk({31'h0, poe[10]}, 32'h0);
        chk({31'h0, timer_capture_in_reg[1]}, 32'h1);
        chk({30'h0, poe[12], pad_pull_en_a_reg[12]}, 32'h0);
        chk({27'h0, usb_pad_route_reg, usb_pad_oe_reg, usb_pad_pull_en_reg}, 32'h10);
        chk({29'h0, serial_periph_clock_in_reg, spi_mosi_in_reg, spi_miso_in_reg}, 32'h3);
        chk({29'h0, uart_receive_line_reg, reset_pin_in_n_reg}, 32'h7);
        remap_wdata = 16'h0100;
        step(1);
        reset_n = 1'b0;
        step(1);
        chk({16'h0, function_remap_select_reg}, 32'h0);
        reset_n = 1'b1;
        step(1);
        report_and_stop();
    end
endmodule
